/* File: charger_i2c_slave_port.sv */
// Two-wire slave port with config registers and fault latch
`timescale 1ns/1ps
`default_nettype none
module charger_i2c_slave_port
  import charger_i2c_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 linkClk,
  input  wire logic                 sclIn,
  output var  logic                 sclOut,
  output var  logic                 sclOe_n,
  input  wire logic                 sdaIn,
  output var  logic                 sdaOut,
  output var  logic                 sdaOe_n,
  input  wire logic [7:0]           faultIn,
  output var  logic [8*NUM_CFG-1:0] cfgFlat,
  output var  logic                 hostInt
);
  // Link domain state
  logic        linkRst;
  logic [1:0]  pinS;
  logic        sclS, sdaS, sclP_q, sdaP_q;
  logic        startEv, stopEv, rise, fall, rxEnd, done, ackSync;
  link_state_t state_q, state_d;
  byte_kind_t  kind_q, kind_d;
  logic [3:0]  bitCnt_q, bitCnt_d;
  logic [7:0]  shift_q, shift_d, idx_q, idx_d, nextIdx;
  logic        first_q, first_d, rw_q, rw_d;
  logic        sdaOeN_q, sdaOeN_d, sclOeN_q, sclOeN_d, pinLow_q;
  logic        reqTog_q, reqTog_d, reqWrite_q, reqWrite_d;
  logic        reqOk_q, reqOk_d;
  logic [7:0]  reqIdx_q, reqIdx_d, reqData_q, reqData_d;

  // Register domain state
  logic        reqSync, reqSeen_q, reqSeen_d, newReq, faultRead;
  logic        ackTog_q, ackTog_d;
  logic        rstHold_q, rstHold_d, rstBack;
  logic [7:0]  rdData_q, rdData_d;
  logic [7:0]  cfg_q [NUM_CFG];
  logic [7:0]  cfg_d [NUM_CFG];

  fault_if fl ();

  // Reset reaches the link domain through a synchroniser; a reset
  // shorter than a link clock is held until the link side echoes it
  sync_2ff #(.WIDTH(1), .RST(1'b1)) u_rstSync (
    .clk   (linkClk),
    .reset (1'b0),
    .d     (rstHold_q),
    .q     (linkRst)
  );

  // Echo of the link reset ends the hold
  sync_2ff #(.WIDTH(1), .RST(1'b0)) u_rstBack (
    .clk   (ref_clk),
    .reset (reset),
    .d     (linkRst),
    .q     (rstBack)
  );

  // Pins are sampled twice before use; idle bus reads high
  sync_2ff #(.WIDTH(2), .RST(2'h3)) u_pinSync (
    .clk   (linkClk),
    .reset (linkRst),
    .d     ({sclIn, sdaIn}),
    .q     (pinS)
  );

  // Completion toggle from the register domain
  sync_2ff #(.WIDTH(1), .RST(1'b0)) u_ackSync (
    .clk   (linkClk),
    .reset (linkRst),
    .d     (ackTog_q),
    .q     (ackSync)
  );

  // Request toggle into the register domain
  sync_2ff #(.WIDTH(1), .RST(1'b0)) u_reqSync (
    .clk   (ref_clk),
    .reset (reset),
    .d     (reqTog_q),
    .q     (reqSync)
  );

  fault_latch u_fault (
    .clk   (ref_clk),
    .reset (reset),
    .f     (fl.owner)
  );

  // Bus events from synchronised samples; link clock is many times
  // faster than a fast-mode bit, so no pulse is missed
  assign sclS    = pinS[1];
  assign sdaS    = pinS[0];
  assign startEv = sclS && sclP_q && sdaP_q && !sdaS;
  assign stopEv  = sclS && sclP_q && !sdaP_q && sdaS;
  assign rise    = sclS && !sclP_q;
  assign fall    = !sclS && sclP_q;
  assign rxEnd   = (state_q == S_RX) && fall && (bitCnt_q == BITS_PER_BYTE);
  assign done    = (ackSync == reqTog_q);
  assign nextIdx = 8'(idx_q + 8'h01);

  // Protocol engine next state
  always_comb begin
    state_d    = state_q;
    kind_d     = kind_q;
    bitCnt_d   = bitCnt_q;
    shift_d    = shift_q;
    idx_d      = idx_q;
    first_d    = first_q;
    rw_d       = rw_q;
    sdaOeN_d   = sdaOeN_q;
    sclOeN_d   = sclOeN_q;
    reqTog_d   = reqTog_q;
    reqWrite_d = reqWrite_q;
    reqIdx_d   = reqIdx_q;
    reqData_d  = reqData_q;
    reqOk_d    = reqOk_q;
    // Only the master frames a transfer; a stop frees the bus
    if (stopEv) begin
      state_d  = S_IDLE;
      sdaOeN_d = 1'b1;
      sclOeN_d = 1'b1;
    end else if (startEv) begin
      // Start and repeated start both open an address byte
      state_d  = S_RX;
      kind_d   = K_ADDR;
      bitCnt_d = 4'h0;
      sdaOeN_d = 1'b1;
      sclOeN_d = 1'b1;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          sdaOeN_d = 1'b1;
          sclOeN_d = 1'b1;
        end
        S_RX: begin
          if (rise && bitCnt_q != BITS_PER_BYTE) begin
            shift_d  = {shift_q[6:0], sdaS};
            bitCnt_d = 4'(bitCnt_q + 4'h1);
          end else if (rxEnd) begin
            bitCnt_d = 4'h0;
            unique case (kind_q)
              K_ADDR: begin
                if (shift_q[7:1] == SLAVE_ADDR) begin
                  sdaOeN_d = 1'b0;
                  rw_d     = shift_q[0];
                  kind_d   = K_INDEX;
                  state_d  = S_ACK;
                  if (shift_q[0]) begin
                    reqTog_d   = ~reqTog_q;
                    reqWrite_d = 1'b0;
                    reqIdx_d   = idx_q;
                    reqOk_d    = regDefined(idx_q, first_q);
                  end
                end else begin
                  state_d = S_IDLE;
                end
              end
              K_INDEX: begin
                if (shift_q <= FAULT_LATCH_IDX) begin
                  sdaOeN_d = 1'b0;
                  idx_d    = shift_q;
                  first_d  = 1'b1;
                  kind_d   = K_DATA;
                  state_d  = S_ACK;
                end else begin
                  state_d = S_IDLE;
                end
              end
              K_DATA: begin
                // Fault latch past the first byte is refused
                if (regDefined(idx_q, first_q)) begin
                  sdaOeN_d   = 1'b0;
                  sclOeN_d   = 1'b0;
                  reqTog_d   = ~reqTog_q;
                  reqWrite_d = 1'b1;
                  reqIdx_d   = idx_q;
                  reqData_d  = shift_q;
                  reqOk_d    = 1'b1;
                  state_d    = S_WAIT;
                end else begin
                  state_d = S_IDLE;
                end
              end
              default: state_d = S_IDLE;
            endcase
          end
        end
        S_WAIT: begin
          // Clock held low until the register domain has the byte
          if (done) begin
            sclOeN_d = 1'b1;
            idx_d    = nextIdx;
            first_d  = 1'b0;
            state_d  = S_ACK;
          end
        end
        S_ACK: begin
          // Ack stays low through the ninth pulse
          if (fall) begin
            sdaOeN_d = 1'b1;
            bitCnt_d = 4'h0;
            state_d  = rw_q ? S_RDWAIT : S_RX;
          end
        end
        S_RDWAIT: begin
          if (!sclS) begin
            if (done) begin
              shift_d  = rdData_q;
              sdaOeN_d = rdData_q[7];
              bitCnt_d = 4'h0;
              state_d  = S_TX;
            end else begin
              sclOeN_d = 1'b0;
            end
          end
        end
        S_TX: begin
          // Clock freed one cycle after the first bit is set up
          sclOeN_d = 1'b1;
          if (fall) begin
            if (bitCnt_q == LAST_TX_BIT) begin
              sdaOeN_d = 1'b1;
              state_d  = S_TXACK;
            end else begin
              shift_d  = {shift_q[6:0], 1'b1};
              sdaOeN_d = shift_q[6];
              bitCnt_d = 4'(bitCnt_q + 4'h1);
            end
          end
        end
        S_TXACK: begin
          if (rise) begin
            if (!sdaS) begin
              idx_d      = nextIdx;
              first_d    = 1'b0;
              reqTog_d   = ~reqTog_q;
              reqWrite_d = 1'b0;
              reqIdx_d   = nextIdx;
              reqOk_d    = regDefined(nextIdx, 1'b0);
              state_d    = S_RDWAIT;
            end else begin
              state_d = S_IDLE;
            end
          end
        end
        default: begin
          state_d  = S_IDLE;
          sdaOeN_d = 1'b1;
          sclOeN_d = 1'b1;
        end
      endcase
    end
  end

  // Protocol engine registers
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      sclP_q     <= 1'b1;
      sdaP_q     <= 1'b1;
      state_q    <= S_IDLE;
      kind_q     <= K_ADDR;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      idx_q      <= FIRST_CFG_IDX;
      first_q    <= 1'b0;
      rw_q       <= 1'b0;
      sdaOeN_q   <= 1'b1;
      sclOeN_q   <= 1'b1;
      pinLow_q   <= 1'b0;
      reqTog_q   <= 1'b0;
      reqWrite_q <= 1'b0;
      reqIdx_q   <= 8'h00;
      reqData_q  <= 8'h00;
      reqOk_q    <= 1'b0;
    end else begin
      sclP_q     <= sclS;
      sdaP_q     <= sdaS;
      state_q    <= state_d;
      kind_q     <= kind_d;
      bitCnt_q   <= bitCnt_d;
      shift_q    <= shift_d;
      idx_q      <= idx_d;
      first_q    <= first_d;
      rw_q       <= rw_d;
      sdaOeN_q   <= sdaOeN_d;
      sclOeN_q   <= sclOeN_d;
      pinLow_q   <= 1'b0;
      reqTog_q   <= reqTog_d;
      reqWrite_q <= reqWrite_d;
      reqIdx_q   <= reqIdx_d;
      reqData_q  <= reqData_d;
      reqOk_q    <= reqOk_d;
    end
  end

  // Pins never drive high, only low or released
  assign sclOut  = pinLow_q;
  assign sdaOut  = pinLow_q;
  assign sclOe_n = sclOeN_q;
  assign sdaOe_n = sdaOeN_q;

  // Register side: request fields stay still until the ack toggle
  // returns, so they cross without their own synchronisers
  assign newReq = reqSync ^ reqSeen_q;

  always_comb begin
    cfg_d     = cfg_q;
    rdData_d  = rdData_q;
    ackTog_d  = ackTog_q;
    reqSeen_d = reqSeen_q;
    faultRead = 1'b0;
    rstHold_d = rstHold_q;
    if (rstBack) begin
      rstHold_d = 1'b0;
    end
    if (newReq) begin
      reqSeen_d = reqSync;
      ackTog_d  = ~ackTog_q;
      if (reqWrite_q) begin
        // Writes to the fault latch are taken but change nothing
        if (reqOk_q && reqIdx_q <= LAST_CFG_IDX) begin
          cfg_d[reqIdx_q[3:0]] = reqData_q;
        end
      end else if (!reqOk_q) begin
        rdData_d = UNDEF_READ;
      end else if (reqIdx_q == FAULT_LATCH_IDX) begin
        rdData_d  = fl.latched;
        faultRead = 1'b1;
      end else begin
        rdData_d = cfg_q[reqIdx_q[3:0]];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_q[i] <= CFG_RESET;
      end
      rdData_q  <= 8'h00;
      ackTog_q  <= 1'b0;
      reqSeen_q <= 1'b0;
      rstHold_q <= 1'b1;
    end else begin
      cfg_q     <= cfg_d;
      rdData_q  <= rdData_d;
      ackTog_q  <= ackTog_d;
      reqSeen_q <= reqSeen_d;
      rstHold_q <= rstHold_d;
    end
  end

  // Fault latch hookup; interrupt comes from its flop
  assign fl.faultNow   = faultIn;
  assign fl.readStrobe = faultRead;
  assign hostInt       = fl.intPulse;

  for (genvar g = 0; g < NUM_CFG; g++) begin : g_cfg
    assign cfgFlat[8*g +: 8] = cfg_q[g];
  end

  addr_match_a: assert property (@(posedge linkClk) disable iff (linkRst)
    (rxEnd && kind_q == K_ADDR && shift_q[7:1] != SLAVE_ADDR)
      |=> state_q == S_IDLE && sdaOeN_q)
    else $error("foreign address acknowledged");

  sda_hold_a: assert property (@(posedge linkClk) disable iff (linkRst)
    (sclS && sclP_q && sdaOeN_q) |=> sdaOeN_q)
    else $error("data pulled low during clock high");

  start_open_a: assert property (@(posedge linkClk) disable iff (linkRst)
    startEv |=> state_q == S_RX && bitCnt_q == 4'h0)
    else $error("start not taken");

  stop_free_a: assert property (@(posedge linkClk) disable iff (linkRst)
    stopEv |=> state_q == S_IDLE && sdaOeN_q && sclOeN_q)
    else $error("stop did not release bus");

  ack_low_a: assert property (@(posedge linkClk) disable iff (linkRst)
    (state_q == S_ACK) |-> !sdaOeN_q)
    else $error("ack not held low");

  index_nack_a: assert property (@(posedge linkClk) disable iff (linkRst)
    (rxEnd && kind_q == K_INDEX && shift_q > FAULT_LATCH_IDX)
      |=> state_q == S_IDLE && sdaOeN_q)
    else $error("undefined index acknowledged");

  stretch_hold_a: assert property (@(posedge linkClk) disable iff (linkRst)
    (state_q == S_WAIT && !done) |=> !sclOeN_q)
    else $error("clock released before write done");

  burst_step_a: assert property (@(posedge linkClk) disable iff (linkRst)
    (state_q == S_WAIT && done) |=> idx_q == 8'($past(idx_q) + 8'h01))
    else $error("index did not advance");

  cfg_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    (newReq && reqWrite_q && reqOk_q && reqIdx_q <= LAST_CFG_IDX)
      |=> cfg_q[reqIdx_q[3:0]] == reqData_q)
    else $error("config write lost");
endmodule
`default_nettype wire

/* File: charger_i2c_pkg.sv */
// Shared constants and types for the charger two-wire slave port
`default_nettype none
package charger_i2c_pkg;
  // Bus identity and register map
  localparam logic [6:0] SLAVE_ADDR      = 7'h6B;
  localparam int         NUM_CFG         = 9;
  localparam logic [7:0] FIRST_CFG_IDX   = 8'h00;
  localparam logic [7:0] LAST_CFG_IDX    = 8'h08;
  localparam logic [7:0] FAULT_LATCH_IDX = 8'h09;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam logic [7:0] UNDEF_READ      = 8'hFF;
  localparam logic [7:0] WDOG_FAULT_MASK = 8'h80;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0] LAST_TX_BIT     = 4'h7;
  // Link timing: the shortest fast-mode bit must span many link clocks
  localparam int STD_KBPS       = 100;
  localparam int FAST_KBPS      = 400;
  localparam int LINK_CLK_NS    = 160;
  localparam int FAST_BIT_NS    = 1000000 / FAST_KBPS;
  localparam int LINK_PER_FAST  = FAST_BIT_NS / LINK_CLK_NS;
  localparam int STD_BIT_NS     = 1000000 / STD_KBPS;
  localparam int LINK_PER_STD   = STD_BIT_NS / LINK_CLK_NS;

  typedef enum logic [6:0] {
    S_IDLE   = 7'h01,
    S_RX     = 7'h02,
    S_ACK    = 7'h04,
    S_WAIT   = 7'h08,
    S_RDWAIT = 7'h10,
    S_TX     = 7'h20,
    S_TXACK  = 7'h40
  } link_state_t;

  typedef enum logic [2:0] {
    K_ADDR  = 3'h1,
    K_INDEX = 3'h2,
    K_DATA  = 3'h4
  } byte_kind_t;

  // Fault latch only takes the first data byte of a transfer
  function automatic logic regDefined(input logic [7:0] idx,
                                      input logic       first);
    return (idx <= LAST_CFG_IDX) || ((idx == FAULT_LATCH_IDX) && first);
  endfunction
endpackage
`default_nettype wire

/* File: fault_if.sv */
// Carrier between the port and its fault latch
`timescale 1ns/1ps
`default_nettype none
interface fault_if;
  logic [7:0] faultNow;
  logic [7:0] latched;
  logic       readStrobe;
  logic       intPulse;
  modport owner (input faultNow, input readStrobe,
                 output latched, output intPulse);
  modport user  (output faultNow, output readStrobe,
                 input latched, input intPulse);
endinterface
`default_nettype wire

/* File: sync_2ff.sv */
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] RST   = '0
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= RST;
      q      <= RST;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: fault_latch.sv */
// Read-to-clear fault latch and one-shot host interrupt
`timescale 1ns/1ps
`default_nettype none
module fault_latch
  import charger_i2c_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  fault_if.owner    f
);
  logic [7:0] latched_q, latched_d, prev_q;
  logic       armed_q, armed_d, readSeen_q, readSeen_d, int_q, int_d;
  logic       fire;

  assign fire = armed_q && |(f.faultNow & ~prev_q);

  // A read reloads the latch with the live faults, so a fault present
  // in the clearing cycle survives
  always_comb begin
    latched_d  = f.readStrobe ? f.faultNow : (latched_q | f.faultNow);
    int_d      = fire;
    readSeen_d = f.readStrobe ? 1'b1 : readSeen_q;
    armed_d    = armed_q;
    if (fire) begin
      armed_d    = 1'b0;
      readSeen_d = 1'b0;
    end else if (!armed_q && readSeen_q &&
                 ((f.faultNow & ~WDOG_FAULT_MASK) == 8'h00)) begin
      armed_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      latched_q  <= 8'h00;
      prev_q     <= 8'h00;
      armed_q    <= 1'b1;
      readSeen_q <= 1'b0;
      int_q      <= 1'b0;
    end else begin
      latched_q  <= latched_d;
      prev_q     <= f.faultNow;
      armed_q    <= armed_d;
      readSeen_q <= readSeen_d;
      int_q      <= int_d;
    end
  end

  assign f.latched  = latched_q;
  assign f.intPulse = int_q;

  latch_clear_a: assert property (@(posedge clk) disable iff (reset)
    f.readStrobe |=> latched_q == $past(f.faultNow))
    else $error("fault latch not reloaded by read");

  int_oneshot_a: assert property (@(posedge clk) disable iff (reset)
    int_q |-> !armed_q ##1 !int_q)
    else $error("interrupt not one-shot");
endmodule
`default_nettype wire

/* File: i2c_master_model.sv */
// Host-side bus master model that clocks the two-wire link
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
  parameter int Q = 625
) (
  input  wire logic       sclW,
  input  wire logic       sdaW,
  output var  logic       sclLow,
  output var  logic       sdaLow,
  output var  logic [7:0] obsVal,
  output var  logic       obsStrobe,
  output var  logic       stuck
);
  // Lines start released; the clock stands still between frames
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    obsVal = 8'h00;
    obsStrobe = 1'b0;
    stuck = 1'b0;
  end
  // Release the clock, then wait out any stretching, bounded
  task automatic sclRise();
    int i;
    sclLow = 1'b0;
    for (i = 0; i < 2000 && sclW !== 1'b1; i++) #10;
    if (sclW !== 1'b1) stuck = 1'b1;
  endtask
  // One bit at 400 kbit/s; data moves only in the low phase
  task automatic bitIo(input logic b, output logic s);
    #Q sdaLow = ~b;
    #Q sclRise();
    #Q s = sdaW;
    #Q sclLow = 1'b1;
  endtask
  task automatic report(input logic [7:0] v);
    obsVal = v;
    obsStrobe = 1'b1;
    #1 obsStrobe = 1'b0;
  endtask
  // START, or repeated START when the clock is still held low
  task automatic startC();
    if (sclLow) begin
      #Q sdaLow = 1'b0;
      #Q sclRise();
      #Q;
    end
    sdaLow = 1'b1;
    #Q sclLow = 1'b1;
  endtask
  task automatic stopC();
    #Q sdaLow = 1'b1;
    #Q sclRise();
    #Q sdaLow = 1'b0;
    #Q;
  endtask
  // Byte out MSB first; ninth pulse with data released carries the ack
  task automatic sendByte(input logic [7:0] b);
    logic s;
    int   i;
    for (i = 7; i >= 0; i--) bitIo(b[i], s);
    bitIo(1'b1, s);
    report({7'h00, s});
  endtask
  // Byte in; master answers ack to go on, NACK to finish
  task automatic readByte(input logic ackIt);
    logic [7:0] v;
    logic       s;
    int         i;
    for (i = 7; i >= 0; i--) begin
      bitIo(1'b1, s);
      v[i] = s;
    end
    bitIo(~ackIt, s);
    report(v);
  endtask
endmodule
`default_nettype wire

/* File: charger_i2c_slave_port_bench.sv */
// Self-checking bench for the charger two-wire slave port
`timescale 1ns/1ps
`default_nettype none
module charger_i2c_slave_port_bench;
  import charger_i2c_pkg::*;
  logic                 ref_clk, linkClk, reset;
  logic [7:0]           faultIn, obsVal;
  logic                 sclOut, sclOe_n, sdaOut, sdaOe_n, hostInt;
  logic [8*NUM_CFG-1:0] cfgFlat;
  logic                 sclLow, sdaLow, obsStrobe, stuck, sclW, sdaW, live;
  logic [7:0]           expQ[$];
  logic [7:0]           mirror[0:8];
  int                   mismatches, compares, intCount, seed;

  // Open-drain wires with pull-up: low if any party pulls
  assign sclW = (sclOe_n === 1'b0 || sclLow) ? 1'b0 : 1'b1;
  assign sdaW = (sdaOe_n === 1'b0 || sdaLow) ? 1'b0 : 1'b1;
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Link clock free running, phase unrelated to ref_clk
  initial begin
    linkClk = 1'b0;
    #37;
    forever #80 linkClk = ~linkClk;
  end

  charger_i2c_slave_port i_charger_i2c_slave_port (
    .ref_clk(ref_clk), .reset(reset), .linkClk(linkClk),
    .sclIn(sclW), .sclOut(sclOut), .sclOe_n(sclOe_n),
    .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .faultIn(faultIn), .cfgFlat(cfgFlat), .hostInt(hostInt));
  i2c_master_model i_i2c_master_model (
    .sclW(sclW), .sdaW(sdaW), .sclLow(sclLow), .sdaLow(sdaLow),
    .obsVal(obsVal), .obsStrobe(obsStrobe), .stuck(stuck));

  task automatic check(input string name, input logic [71:0] seen,
                       input logic [71:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Every ack bit and read byte is matched against the oldest note
  always @(posedge obsStrobe) begin
    if (expQ.size() == 0) check("spare result", 72'(obsVal), 72'h1FF);
    else check("bus result", 72'(obsVal), 72'(expQ.pop_front()));
  end
  // A hung clock stretch ends the run at once
  always @(posedge stuck) begin
    mismatches++;
    conclude();
  end
  always @(posedge ref_clk) if (hostInt === 1'b1) intCount++;
  // Device may only pull low, and may move data only while clock is low
  always @(sdaOe_n) if (live === 1'b1) begin
    check("sda drive level", 72'(sdaOut), 72'h0);
    check("scl at sda change", 72'(sclW), 72'h0);
  end
  always @(sclOe_n) if (live === 1'b1)
    check("scl drive", 72'(sclOut), 72'h0);

  task automatic sendExp(input logic [7:0] b, input logic [7:0] ack);
    expQ.push_back(ack);
    i_i2c_master_model.sendByte(b);
  endtask
  // Write n random bytes from idx; lastAck is expected on the final one
  task automatic wrRegs(input logic [7:0] idx, input int n,
                        input logic [7:0] lastAck);
    logic [7:0] d;
    int         i;
    i_i2c_master_model.startC();
    sendExp(8'hD6, 8'h00);
    sendExp(idx, (idx > FAULT_LATCH_IDX) ? 8'h01 : 8'h00);
    for (i = 0; i < n; i++) begin
      d = 8'($random(seed));
      sendExp(d, (i == n - 1) ? lastAck : 8'h00);
      if (idx + i <= 8) mirror[idx + i] = d;
    end
    i_i2c_master_model.stopC();
  endtask
  // Index write, repeated START, n reads; a latch read as the first byte expects latchExp
  task automatic rdRegs(input logic [7:0] idx, input int n,
                        input logic [7:0] latchExp);
    int i;
    i_i2c_master_model.startC();
    sendExp(8'hD6, 8'h00);
    sendExp(idx, 8'h00);
    i_i2c_master_model.startC();
    sendExp(8'hD7, 8'h00);
    for (i = 0; i < n; i++) begin
      // Burst past the last config register reads the undefined value
      if (idx + i == FAULT_LATCH_IDX && i == 0) expQ.push_back(latchExp);
      else if (idx + i > LAST_CFG_IDX) expQ.push_back(UNDEF_READ);
      else expQ.push_back(mirror[idx + i]);
      i_i2c_master_model.readByte(i < n - 1);
    end
    i_i2c_master_model.stopC();
  endtask
  task automatic checkCfg();
    logic [71:0] e;
    int          i;
    for (i = 0; i < 9; i++) e[8*i +: 8] = mirror[i];
    check("config image", cfgFlat, e);
  endtask
  task automatic setFault(input logic [7:0] f);
    @(posedge ref_clk);
    #2 faultIn = f;
    repeat (20) @(posedge ref_clk);
  endtask

  // Main sequence; the port carries a short reset into the link domain
  initial begin
    logic [6:0] a;
    int         k;
    seed = 32'h5091;
    reset = 1'b1;
    faultIn = 8'h00;
    mismatches = 0;
    compares = 0;
    intCount = 0;
    live = 1'b0;
    for (k = 0; k < 9; k++) mirror[k] = CFG_RESET;
    repeat (6) @(posedge ref_clk);
    #2 reset = 1'b0;
    checkCfg();
    // Link side leaves reset a few link clocks later
    #1000;
    check("reset pins", 72'({sclOe_n, sdaOe_n, sclOut, sdaOut, hostInt}),
          72'h18);
    live = 1'b1;
    a = 7'($random(seed));
    if (a == SLAVE_ADDR) a = a ^ 7'h01;
    i_i2c_master_model.startC();
    sendExp({a, 1'b0}, 8'h01);
    i_i2c_master_model.stopC();
    // Single accesses at both ends and the middle of the map
    for (k = 0; k < 3; k++) begin
      wrRegs(8'(4 * k), 1, 8'h00);
      rdRegs(8'(4 * k), 1, 8'h00);
    end
    checkCfg();
    wrRegs(FIRST_CFG_IDX, 9, 8'h00);
    rdRegs(FIRST_CFG_IDX, 9, 8'h00);
    checkCfg();
    wrRegs(8'h0A, 0, 8'h00);
    wrRegs(LAST_CFG_IDX, 2, 8'h01);
    wrRegs(FAULT_LATCH_IDX, 1, 8'h00);
    rdRegs(LAST_CFG_IDX, 2, 8'h00);
    checkCfg();
    // Fault recovers before the host looks; a later bit raises no pulse
    setFault(8'h02);
    setFault(8'h06);
    setFault(8'h00);
    check("interrupt count", 72'(intCount), 72'd1);
    rdRegs(FAULT_LATCH_IDX, 1, 8'h06);
    rdRegs(FAULT_LATCH_IDX, 1, 8'h00);
    setFault(8'h01);
    check("interrupt rearm", 72'(intCount), 72'd2);
    for (k = 0; k < 100 && expQ.size() != 0; k++) @(posedge ref_clk);
    check("results left", 72'(expQ.size()), 72'd0);
    conclude();
  end
endmodule
`default_nettype wire
